// ---- hw/spi_master_slave_core.sv ----
// Byte serial shift engine, master or slave, with core-side data and status ports
// Function
// R1 - Master never drives or sequences slave select by itself.
// R2 - Software lowers the slave select before a master transfer.
// R3 - Master write of data starts SCK and shifts exactly eight bits.
// R4 - After one byte the clock halts and done flag sets.
// R5 - Done flag with irq enable raises interrupt request in both modes.
// R6 - Master to slave on MOSI, slave to master on MISO, full duplex.
// R7 - Software raises slave select after each packet.
// R8 - Slave with select high stays idle, MISO released.
// R9 - Slave data written while deselected shifts only after select falls.
// R10 - Slave sets done flag once a full byte is in.
// R11 - Last received byte held in buffer, returned on data reads.
// R12 - Software must not write data during a shift.
// R13 - Receive double buffered; unread earlier byte is overwritten.
// R14 - External SCK high and low each longer than two core cycles.
// R15 - Enabled block forces pin directions per mode.
// R16 - Master offers seven rates including half core clock.
// R17 - Two rate bits plus double speed pick /2 to /128; slave ignores.
// R18 - Master with SS input low drops to slave and sets done flag.
// R19 - Data write during transfer sets write collision flag.
// R20 - Status read with flag set then data access clears flags; vector clears too.
// R21 - Bit order selects LSB or MSB first for both directions.
// R22 - Polarity and phase set idle level and sample edge; launch opposite.
module spi_master_slave_core (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire serial_core_pkg::serial_cfg_t i_cfg,
  input wire logic i_master_set,
  input wire logic i_ss_is_input,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_data_rd,
  input wire logic i_status_rd,
  input wire logic i_irq_ack,
  input wire logic i_sck_in,
  input wire logic i_mosi_in,
  input wire logic i_ss_n_in,
  input wire logic i_spi_link_clk,
  output logic [7:0] o_serial_data_reg,
  output logic o_xfer_done_flag,
  output logic o_write_collision_flag,
  output logic o_master_select,
  output logic o_busy,
  output logic o_irq,
  output serial_core_pkg::serial_pins_t o_pins,
  output serial_core_pkg::serial_pins_t o_pins_oe
);
  import serial_core_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sck_prev_reg;
  logic link_alive_reg;
  logic [1:0] link_seen_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 3'h1; // SCK and its edge history agree, no false edge
      sync2_reg <= 3'h1;
      sck_prev_reg <= 1'b0;
      link_seen_reg <= 2'h0;
    end else begin
      sync1_reg <= {i_sck_in, i_mosi_in, i_ss_n_in};
      sync2_reg <= sync1_reg;
      sck_prev_reg <= sync2_reg[2];
      link_seen_reg <= {link_seen_reg[0], link_alive_reg};
    end
  end
  logic sck_s, mosi_s, ss_n_s;
  assign sck_s = sync2_reg[2];
  assign mosi_s = sync2_reg[1];
  assign ss_n_s = sync2_reg[0];

  // Link clock presence, brought into the core domain through two flops
  always_ff @(posedge i_spi_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) link_alive_reg <= 1'b0;
    else link_alive_reg <= 1'b1;
  end

  // ==========================================================
  // Mode and shift engine
  // ==========================================================
  logic master_reg;
  master_state_t st_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [5:0] div_reg;
  logic sck_out_reg;
  logic mosi_out_reg;
  logic sampled_reg;
  logic [5:0] half_cnt;
  logic slave_active;
  logic mode_fault;
  logic done_pulse;
  logic lsb_first;
  logic ser_out;

  assign lsb_first = i_cfg.bit_order_sel; // see R21
  assign ser_out = lsb_first ? shift_reg[0] : shift_reg[7];
  assign slave_active = i_cfg.serial_block_enable && !master_reg && !ss_n_s;
  // see R18
  assign mode_fault = i_cfg.serial_block_enable && master_reg && i_ss_is_input && !ss_n_s;

  always_comb begin
    case ({i_cfg.double_speed_sel, i_cfg.rate_sel_hi, i_cfg.rate_sel_lo}) // see R16, R17
      3'h0: half_cnt = HALF_DIV4;
      3'h1: half_cnt = HALF_DIV16;
      3'h2: half_cnt = HALF_DIV64;
      3'h3: half_cnt = HALF_DIV128;
      3'h4: half_cnt = HALF_DIV2;
      3'h5: half_cnt = HALF_DIV8;
      3'h6: half_cnt = HALF_DIV32;
      default: half_cnt = HALF_DIV64;
    endcase
  end

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) master_reg <= 1'b0;
    else if (mode_fault) master_reg <= 1'b0; // see R18
    else if (i_master_set) master_reg <= 1'b1;
  end

  // Edge pair in the core domain: leading then trailing per bit
  logic s_lead, s_trail;
  assign s_lead = slave_active && (sck_s != sck_prev_reg) && (sck_s != i_cfg.clock_idle_level);
  assign s_trail = slave_active && (sck_s != sck_prev_reg) && (sck_s == i_cfg.clock_idle_level);

  logic transfer_busy;
  assign transfer_busy = (st_reg != ST_IDLE) || (slave_active && sampled_reg);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= ST_IDLE;
      shift_reg <= DATA_RST;
      bit_reg <= 3'h0;
      div_reg <= 6'h00;
      sck_out_reg <= 1'b0;
      mosi_out_reg <= 1'b0;
      sampled_reg <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      sck_out_reg <= i_cfg.clock_idle_level;
      if (master_reg && !mode_fault && i_cfg.serial_block_enable) begin
        sck_out_reg <= sck_out_reg;
        case (st_reg)
          ST_IDLE: begin
            sck_out_reg <= i_cfg.clock_idle_level; // see R22
            if (i_data_wr) begin // see R3
              shift_reg <= i_data_wdata;
              mosi_out_reg <= lsb_first ? i_data_wdata[0] : i_data_wdata[7];
              bit_reg <= 3'h0;
              div_reg <= 6'h00;
              st_reg <= ST_LEAD;
            end
          end
          ST_LEAD: begin
            if (div_reg == half_cnt) begin
              div_reg <= 6'h00;
              sck_out_reg <= !i_cfg.clock_idle_level;
              st_reg <= ST_TRAIL;
              if (!i_cfg.sample_edge_sel) shift_reg <= shift_in(shift_reg, i_mosi_in, lsb_first);
              else mosi_out_reg <= ser_out; // see R22
            end else div_reg <= div_reg + 6'h01;
          end
          ST_TRAIL: begin
            if (div_reg == half_cnt) begin
              div_reg <= 6'h00;
              sck_out_reg <= i_cfg.clock_idle_level;
              if (i_cfg.sample_edge_sel) shift_reg <= shift_in(shift_reg, i_mosi_in, lsb_first);
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == BIT_LAST) begin // see R4
                st_reg <= ST_IDLE;
                done_pulse <= 1'b1;
              end else begin
                st_reg <= ST_LEAD;
                if (!i_cfg.sample_edge_sel) mosi_out_reg <= lsb_first ? shift_reg[0] : shift_reg[7];
              end
            end else div_reg <= div_reg + 6'h01;
          end
          default: st_reg <= ST_IDLE;
        endcase
      end else begin
        st_reg <= ST_IDLE;
        if (!slave_active) begin // see R8, R9
          bit_reg <= 3'h0;
          sampled_reg <= 1'b0;
          if (i_data_wr) shift_reg <= i_data_wdata;
          mosi_out_reg <= lsb_first ? shift_reg[0] : shift_reg[7];
        end else begin
          if ((s_lead && !i_cfg.sample_edge_sel) || (s_trail && i_cfg.sample_edge_sel)) begin
            shift_reg <= shift_in(shift_reg, mosi_s, lsb_first);
            sampled_reg <= 1'b1;
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == BIT_LAST) begin // see R10
              done_pulse <= 1'b1;
              sampled_reg <= 1'b0;
            end
          end else if ((s_trail && !i_cfg.sample_edge_sel) || (s_lead && i_cfg.sample_edge_sel)) begin
            mosi_out_reg <= ser_out; // see R22
          end else if (!sampled_reg && bit_reg == 3'h0 && i_data_wr) begin
            shift_reg <= i_data_wdata;
            mosi_out_reg <= lsb_first ? i_data_wdata[0] : i_data_wdata[7];
          end
        end
      end
    end
  end

  // ==========================================================
  // Receive buffer, flags, interrupt
  // ==========================================================
  logic armed_reg;
  logic flag_done_reg, flag_write_collision_flag_reg, irq_reg, busy_reg;
  logic [7:0] rx_buf_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) rx_buf_reg <= DATA_RST;
    else if (done_pulse) rx_buf_reg <= shift_reg; // see R11, R13
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) armed_reg <= 1'b0;
    else if (i_data_rd || i_data_wr) armed_reg <= 1'b0;
    else if (i_status_rd && (flag_done_reg || flag_write_collision_flag_reg)) armed_reg <= 1'b1;
  end

  logic data_access;
  assign data_access = (i_data_rd || i_data_wr) && armed_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_done_reg <= 1'b0;
      flag_write_collision_flag_reg <= 1'b0;
    end else begin
      if (done_pulse || mode_fault) flag_done_reg <= 1'b1; // see R4, R18
      else if (data_access || i_irq_ack) flag_done_reg <= 1'b0; // see R20
      if (i_data_wr && transfer_busy) flag_write_collision_flag_reg <= 1'b1; // see R19
      else if (data_access) flag_write_collision_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      irq_reg <= i_cfg.xfer_irq_enable && (flag_done_reg || done_pulse || mode_fault)
        && !(i_irq_ack && !done_pulse && !mode_fault); // see R5
      busy_reg <= transfer_busy;
    end
  end

  // ==========================================================
  // Pin outputs and directions
  // ==========================================================
  // SCK and MOSI leave straight from the engine flops, so /2 sampling sees settled data
  logic miso_pin_reg, ss_pin_reg;
  serial_pins_t oe_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      miso_pin_reg <= 1'b0;
      ss_pin_reg <= 1'b0;
      oe_reg <= '0;
    end else begin
      miso_pin_reg <= mosi_out_reg; // see R6
      ss_pin_reg <= 1'b1;
      // see R1, R15: SS never driven; slave MISO only while selected
      oe_reg.sck <= i_cfg.serial_block_enable && master_reg && !mode_fault;
      oe_reg.mosi <= i_cfg.serial_block_enable && master_reg && !mode_fault;
      oe_reg.miso <= slave_active; // see R8
      oe_reg.ss_n <= 1'b0;
    end
  end

  assign o_serial_data_reg = rx_buf_reg;
  assign o_xfer_done_flag = flag_done_reg;
  assign o_write_collision_flag = flag_write_collision_flag_reg;
  assign o_master_select = master_reg;
  assign o_busy = busy_reg;
  assign o_irq = irq_reg;
  assign o_pins = {sck_out_reg, mosi_out_reg, miso_pin_reg, ss_pin_reg};
  assign o_pins_oe = oe_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_ss_never_driven;
    @(posedge i_core_clk) disable iff (!i_rst_n) !o_pins_oe.ss_n;
  endproperty
  a_ss_never_driven: assert property (p_ss_never_driven) else $error("ss driven"); // see R1

  property p_done_irq;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ($rose(flag_done_reg) && i_cfg.xfer_irq_enable && !i_irq_ack) |-> o_irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("irq missing"); // see R5

  property p_miso_released;
    @(posedge i_core_clk) disable iff (!i_rst_n) ss_n_s && !master_reg |=> !o_pins_oe.miso;
  endproperty
  a_miso_released: assert property (p_miso_released) else $error("miso driven"); // see R8

  property p_fault_slave;
    @(posedge i_core_clk) disable iff (!i_rst_n) mode_fault |=> !master_reg && flag_done_reg;
  endproperty
  a_fault_slave: assert property (p_fault_slave) else $error("fault"); // see R18

  property p_write_collision_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n) (i_data_wr && transfer_busy) |=> flag_write_collision_flag_reg;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("write_collision_flag"); // see R19

  property p_done_rx;
    @(posedge i_core_clk) disable iff (!i_rst_n) done_pulse |=> flag_done_reg && rx_buf_reg == $past(shift_reg);
  endproperty
  a_done_rx: assert property (p_done_rx) else $error("rx buf"); // see R10

  property p_start;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_reg == ST_IDLE && master_reg && i_cfg.serial_block_enable && !mode_fault && i_data_wr)
      |=> st_reg == ST_LEAD;
  endproperty
  a_start: assert property (p_start) else $error("no start"); // see R3

  property p_idle_level;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_reg == ST_IDLE) [*2] |-> sck_out_reg == $past(i_cfg.clock_idle_level);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle lvl"); // see R22

  c_master_byte: cover property (@(posedge i_core_clk) master_reg && done_pulse);
  c_slave_byte: cover property (@(posedge i_core_clk) !master_reg && done_pulse);
  c_fault: cover property (@(posedge i_core_clk) mode_fault);
  c_link_seen: cover property (@(posedge i_core_clk) link_seen_reg[1]);
endmodule

// ---- hw/serial_core_pkg.sv ----
// Shared types and constants for the byte serial shift engine
package serial_core_pkg;

  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Half-period terminal counts, core cycles per half period minus one, indexed by {double_speed_sel, rate_sel}
  localparam logic [5:0] HALF_DIV4 = 6'h01;
  localparam logic [5:0] HALF_DIV16 = 6'h07;
  localparam logic [5:0] HALF_DIV64 = 6'h1F;
  localparam logic [5:0] HALF_DIV128 = 6'h3F;
  localparam logic [5:0] HALF_DIV2 = 6'h00;
  localparam logic [5:0] HALF_DIV8 = 6'h03;
  localparam logic [5:0] HALF_DIV32 = 6'h0F;

  typedef struct packed {
    logic serial_block_enable;
    logic xfer_irq_enable;
    logic bit_order_sel;
    logic clock_idle_level;
    logic sample_edge_sel;
    logic rate_sel_hi;
    logic rate_sel_lo;
    logic double_speed_sel;
  } serial_cfg_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } serial_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_TRAIL
  } master_state_t;

endpackage

// ---- verif/spi_far_slave.sv ----
// Behavioural far-side serial slave used while the block is master
module spi_far_slave (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_ss_n,
  input wire logic i_clock_idle_level,
  input wire logic i_sample_edge_sel,
  input wire logic i_lsb,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_in = 0;
  int n_out = 0;
  function automatic int idx(input int k);
    return i_lsb ? k % 8 : 7 - k % 8;
  endfunction
  initial o_miso = 1'b0;
  initial o_rx = 8'h00;
  always @(negedge i_ss_n) begin
    n_in = 0;
    n_out = i_sample_edge_sel ? 0 : 1;
    o_miso = i_tx[idx(0)];
  end
  // Released line floats, so show the inverse and never the stale bit
  always @(posedge i_ss_n) o_miso = ~o_miso;
  always @(i_sck) begin
    if (!i_ss_n && ((i_sck != i_clock_idle_level) != i_sample_edge_sel)) begin
      o_rx[idx(n_in)] = i_mosi;
      n_in++;
    end else if (!i_ss_n) begin
      o_miso = i_tx[idx(n_out)];
      n_out++;
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the byte serial shift engine
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_core_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lclk = 1'b0;
  serial_cfg_t cfg = '0;
  logic mset = 1'b0, ss_in = 1'b0, wr = 1'b0, rd = 1'b0, srd = 1'b0, ack = 1'b0;
  logic b_sck = 1'b0, b_mosi = 1'b0, b_ss = 1'b1, far_on = 1'b1, ss_gpio = 1'b1;
  logic [7:0] wdata = 8'h00, far_tx = 8'h00, tx_q, rx_q, dreg, far_rx;
  logic done, write_collision_flag, msel, busy, irq, far_miso;
  serial_pins_t pins, oe;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] lfsr_q = 32'hAC3F13FC;

  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #3.1;
    forever #62.5 lclk = ~lclk;
  end

  spi_master_slave_core i_spi_master_slave_core (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_master_set(mset),
    .i_ss_is_input(ss_in), .i_data_wr(wr), .i_data_wdata(wdata), .i_data_rd(rd),
    .i_status_rd(srd), .i_irq_ack(ack), .i_sck_in(b_sck),
    .i_mosi_in(far_on ? far_miso : b_mosi), .i_ss_n_in(b_ss), .i_spi_link_clk(lclk),
    .o_serial_data_reg(dreg), .o_xfer_done_flag(done), .o_write_collision_flag(write_collision_flag),
    .o_master_select(msel), .o_busy(busy), .o_irq(irq), .o_pins(pins), .o_pins_oe(oe)
  );
  spi_far_slave i_spi_far_slave (
    .i_sck(pins.sck), .i_mosi(pins.mosi), .i_ss_n(ss_gpio),
    .i_clock_idle_level(cfg.clock_idle_level), .i_sample_edge_sel(cfg.sample_edge_sel),
    .i_lsb(cfg.bit_order_sel), .i_tx(far_tx), .o_miso(far_miso), .o_rx(far_rx)
  );

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  function automatic int div_of(input logic [2:0] c);
    int t[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    return t[c];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        n_fail++;
        $display("ERROR %0t: done flag never set", $time);
        results();
      end
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    time t0;
    repeat (4) @(negedge clk);
    check(dreg, 8'h00);
    check(8'({done, busy, irq, oe.ss_n}), 8'h00);
    rst_n = 1'b1;
    cfg.serial_block_enable = 1'b1;
    @(negedge clk);
    pulse(mset);
    // Every rate code once, with random mode and order, and random data except 80 at code 0
    for (int k = 0; k < 8; k++) begin
      {cfg.double_speed_sel, cfg.rate_sel_hi, cfg.rate_sel_lo} = 3'(k);
      {cfg.bit_order_sel, cfg.clock_idle_level, cfg.sample_edge_sel,
        cfg.xfer_irq_enable} = 4'(rnd());
      far_tx = 8'(rnd() >> 8);
      tx_q = (k == 0) ? 8'h80 : 8'(rnd() >> 16);
      wdata = tx_q;
      repeat (3) @(negedge clk);
      ss_gpio = 1'b0;
      @(negedge clk);
      t0 = $time;
      pulse(wr);
      if (k == 0) begin
        repeat (3) @(negedge clk);
        wdata = 8'hFF;
        pulse(wr);
      end
      wait_done();
      check(8'(($time - t0) / 8 - 8 * div_of(3'(k))) < 8'h05, 8'h01);
      @(negedge clk);
      check(far_rx, tx_q);
      check(dreg, far_tx);
      check(8'(busy), 8'h00);
      check(8'(irq), 8'(cfg.xfer_irq_enable));
      check(8'(write_collision_flag), 8'(k == 0));
      check(8'(pins.sck), 8'(cfg.clock_idle_level));
      check(8'({oe.ss_n, oe.miso}), 8'h00);
      ss_gpio = 1'b1;
      if (k % 2 == 1) begin
        pulse(ack);
      end else begin
        pulse(srd);
        pulse(rd);
      end
      check(8'({done, write_collision_flag}), 8'h00);
    end
    // Another master selects us while the select pin is an input
    ss_in = 1'b1;
    @(negedge clk);
    b_ss = 1'b0;
    repeat (6) @(negedge clk);
    check(8'({msel, done, oe.sck, oe.mosi}), 8'h04);
    b_ss = 1'b1;
    pulse(srd);
    pulse(rd);
    repeat (4) @(negedge clk);
    check(8'(oe.miso), 8'h00);
    far_on = 1'b0;
    cfg = '0;
    cfg.serial_block_enable = 1'b1;
    tx_q = 8'(rnd());
    rx_q = 8'(rnd());
    wdata = tx_q;
    pulse(wr);
    // Clock pulses while deselected must not shift anything out
    repeat (2) begin
      repeat (4) @(negedge clk);
      b_sck = 1'b1;
      repeat (4) @(negedge clk);
      b_sck = 1'b0;
    end
    check(8'(done), 8'h00);
    b_ss = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 7; i >= 0; i--) begin
      check(8'(pins.miso), 8'(tx_q[i]));
      b_mosi = rx_q[i];
      // High phase lasts four core cycles and low phase twelve, both above the minimum
      repeat (4) @(negedge clk);
      b_sck = 1'b1;
      repeat (4) @(negedge clk);
      b_sck = 1'b0;
      repeat (8) @(negedge clk);
    end
    wait_done();
    check(dreg, rx_q);
    b_ss = 1'b1;
    results();
  end
endmodule
